// >>> pcc_pkg.sv
// Package for the phase correction configuration register slice.
// Assumes a 24-bit register word and an 8-bit register address.
package pcc_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] PCC_ADDR_CLIP_MODE = 8'h50;
    localparam logic [7:0] PCC_ADDR_CH0_HIGH = 8'h51;
    localparam logic [7:0] PCC_ADDR_CH1_LOW = 8'h52;
    localparam logic [7:0] PCC_ADDR_CH1_HIGH = 8'h53;
    localparam logic [7:0] PCC_ADDR_BASE = 8'h50;
    localparam int PCC_NUM_REGS = 4;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int PCC_BIT_OVERRIDE = 22;
    localparam int PCC_RSVD_HI = 21;
    localparam int PCC_RSVD_LO = 4;
    localparam logic [17:0] PCC_RSVD_PATTERN = 18'h2_0010;
    localparam int PCC_BIT_CLIP_OFFSET = 3;
    localparam int PCC_BIT_CLIP_TEMP = 2;
    localparam int PCC_BIT_CLIP_NL = 1;
    localparam int PCC_BIT_CLIP_FC = 0;
    localparam int PCC_COEFF_HI_MSB = 23;
    localparam int PCC_COEFF_HI_LSB = 16;
    localparam int PCC_COEFF_LO_MSB = 23;
    localparam int PCC_COEFF_LO_LSB = 20;
    localparam int PCC_BIAS_MSB = 15;
    localparam logic [23:0] PCC_RESET_CLIP_MODE = 24'h20_0100;
    localparam logic [23:0] PCC_RESET_OTHER = 24'h00_0000;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [23:0] data;
    } pcc_write_type;

    typedef struct packed {
        logic manualOverride;
        logic unwrapFrequencySelect;
        logic unwrapEnable;
    } pcc_unwrap_type;

    typedef struct packed {
        logic offsetSaturate;
        logic temperatureSaturate;
        logic linearitySaturate;
        logic frequencySaturate;
    } pcc_clip_type;

    typedef enum {
        PCC_STAGE_OFFSET,
        PCC_STAGE_TEMP,
        PCC_STAGE_LINEARITY,
        PCC_STAGE_FREQUENCY
    } pcc_stage_type;
endpackage

// >>> pcc_reg_mem.sv
// Four-word register storage with registered read data.
// Assumes writes and reads come from the same clock domain.
`timescale 1ns/1ps
module pcc_reg_mem (
    input wire logic clk,
    input wire logic rst,
    input wire logic wrEn,
    input wire logic [1:0] wrIndex,
    input wire logic [23:0] wrData,
    input wire logic [1:0] rdIndex,
    output logic [23:0] rdData,
    output logic [95:0] allWords
);
    import pcc_pkg::*;

    logic [23:0] word_reg [PCC_NUM_REGS];

    genvar g;
    generate
        for (g = 0; g < PCC_NUM_REGS; g++) begin : gWord
            localparam logic [23:0] RESET_VALUE =
                (g == 0) ? PCC_RESET_CLIP_MODE : PCC_RESET_OTHER;
            always_ff @(posedge clk) begin
                if (rst) begin
                    word_reg[g] <= RESET_VALUE;
                end else if (wrEn && (wrIndex == 2'(g))) begin
                    word_reg[g] <= wrData;
                end
            end
            assign allWords[g*24 +: 24] = word_reg[g];
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            rdData <= 24'h00_0000;
        end else begin
            rdData <= word_reg[rdIndex];
        end
    end
endmodule

// >>> pcc_phase_correction_config.sv
// Phase correction configuration registers 50h..53h and the clip or
// wrap behaviour of the four phase correction stages.
// Assumes the control interface delivers one-cycle write strobes and
// read addresses in the clk domain; the datapath feeds raw sums.
//
// Contract
// RQ1: Override bit lets software drive unwrap controls
// RQ2: Software keeps reserved field at fixed pattern
// RQ3: Bit 3 selects offset stage clip/wrap
// RQ4: Bit 2 selects temperature stage clip/wrap
// RQ5: Bit 1 selects linearity stage clip/wrap
// RQ6: Bit 0 selects frequency stage clip/wrap
// RQ7: Channel0 high coefficient split over two registers
// RQ8: Channel0 high phase bias applied at offset
// RQ9: Channel1 low phase bias in next register
// RQ10: Temp_coeff_hi_and_offset_ch1_high holds ch1 high bias, coeff
// RQ11: Clip saturates, wrap keeps modulo result
`timescale 1ns/1ps
module pcc_phase_correction_config (
    input wire logic clk,
    input wire logic rst,
    input pcc_pkg::pcc_write_type hostWrite,
    input wire logic [7:0] hostReadAddr,
    output logic [23:0] hostReadData,
    output logic hostReadHit,
    input wire logic autoFrequencySelect,
    input wire logic autoUnwrapEnable,
    input wire logic manualFrequencySelect,
    input wire logic manualUnwrapEnable,
    output pcc_pkg::pcc_unwrap_type unwrapControl,
    output pcc_pkg::pcc_clip_type clipControl,
    input wire logic [1:0] stageSelect,
    input wire logic signed [16:0] stageRawSum,
    output logic signed [15:0] stageResult,
    output logic [11:0] emitterThermalCoeffCh0High,
    output logic [7:0] emitterThermalCoeffCh1LowUpper,
    output logic [15:0] phaseBiasCh0High,
    output logic [15:0] phaseBiasCh1Low,
    output logic [15:0] phaseBiasCh1High
);
    import pcc_pkg::*;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic logic inRange(input logic [7:0] addr);
        inRange = (addr >= PCC_ADDR_BASE) &&
                  (addr <= PCC_ADDR_CH1_HIGH);
    endfunction

    function automatic logic [1:0] toIndex(input logic [7:0] addr);
        logic [7:0] diff;
        diff = addr - PCC_ADDR_BASE;
        toIndex = diff[1:0];
    endfunction

    wire writeHit = hostWrite.wr && inRange(hostWrite.addr);
    wire [1:0] writeIndex = toIndex(hostWrite.addr);
    wire [1:0] readIndex = toIndex(hostReadAddr);
    wire readInRange = inRange(hostReadAddr);

    // Reserved field is stored as written; hardware does not force the
    // pattern, so a bad write is visible on read back
    wire [23:0] writeData = hostWrite.data; // RQ2

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [95:0] words;

    pcc_reg_mem uMem (
        .clk(clk),
        .rst(rst),
        .wrEn(writeHit),
        .wrIndex(writeIndex),
        .wrData(writeData),
        .rdIndex(readIndex),
        // Storage read port idle; the read path muxes the word bus
        .rdData(),
        .allWords(words)
    );

    wire [23:0] wordClip = words[0*24 +: 24];
    wire [23:0] wordCh0High = words[1*24 +: 24];
    wire [23:0] wordCh1Low = words[2*24 +: 24];
    wire [23:0] wordCh1High = words[3*24 +: 24];

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Zero for unmapped reads is folded in ahead of the flop so the
    // read data pin comes straight from a register
    wire [23:0] readWord = words[readIndex*24 +: 24];
    wire [23:0] readData_next = readInRange ? readWord : 24'h00_0000;
    logic readHit_reg;
    logic [23:0] readData_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            readHit_reg <= 1'b0;
        end else begin
            readHit_reg <= readInRange;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            readData_reg <= 24'h00_0000;
        end else begin
            readData_reg <= readData_next;
        end
    end

    // Unmapped reads return zero one cycle after the address
    assign hostReadData = readData_reg;
    assign hostReadHit = readHit_reg;

    // ------------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------------
    wire overrideBit = wordClip[PCC_BIT_OVERRIDE];
    wire freqNext = overrideBit ? manualFrequencySelect
                                : autoFrequencySelect; // RQ1
    wire enableNext = overrideBit ? manualUnwrapEnable
                                  : autoUnwrapEnable; // RQ1

    pcc_clip_type clipNext;
    assign clipNext.offsetSaturate = wordClip[PCC_BIT_CLIP_OFFSET]; // RQ3
    assign clipNext.temperatureSaturate = wordClip[PCC_BIT_CLIP_TEMP]; // RQ4
    assign clipNext.linearitySaturate = wordClip[PCC_BIT_CLIP_NL]; // RQ5
    assign clipNext.frequencySaturate = wordClip[PCC_BIT_CLIP_FC]; // RQ6

    wire [11:0] coeffCh0Next = {
        wordCh0High[PCC_COEFF_HI_MSB:PCC_COEFF_HI_LSB],
        wordCh1Low[PCC_COEFF_LO_MSB:PCC_COEFF_LO_LSB]}; // RQ7

    // ------------------------------------------------------------------
    // Stage saturate or wrap
    // ------------------------------------------------------------------
    logic stageClip;
    always_comb begin
        case (stageSelect)
            2'h0: stageClip = clipNext.offsetSaturate; // RQ3
            2'h1: stageClip = clipNext.temperatureSaturate; // RQ4
            2'h2: stageClip = clipNext.linearitySaturate; // RQ5
            2'h3: stageClip = clipNext.frequencySaturate; // RQ6
            default: stageClip = 1'b0;
        endcase
    end

    // Overflow when the two top bits of the 17-bit sum disagree; the
    // wider sum keeps the true sign, so the limit is picked from it
    function automatic logic [15:0] fitPhase(input logic [16:0] sum,
        input logic clip);
        logic overflow;
        overflow = sum[16] ^ sum[15];
        if (clip && overflow) begin
            fitPhase = sum[16] ? 16'h8000 : 16'h7FFF;
        end else begin
            fitPhase = sum[15:0];
        end
    endfunction

    wire signed [15:0] resultNext = fitPhase(stageRawSum, stageClip); // RQ11

    // ------------------------------------------------------------------
    // Unwrap control output
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            unwrapControl <= '0;
        end else begin
            unwrapControl <= '{overrideBit, freqNext, enableNext}; // RQ1
        end
    end

    // ------------------------------------------------------------------
    // Stage mode and stage result outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            clipControl <= '0;
        end else begin
            clipControl <= clipNext;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stageResult <= 16'sh0000;
        end else begin
            stageResult <= resultNext; // RQ11
        end
    end

    // ------------------------------------------------------------------
    // Coefficient outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            emitterThermalCoeffCh0High <= 12'h000;
            emitterThermalCoeffCh1LowUpper <= 8'h00;
        end else begin
            emitterThermalCoeffCh0High <= coeffCh0Next; // RQ7
            emitterThermalCoeffCh1LowUpper <=
                wordCh1High[PCC_COEFF_HI_MSB:PCC_COEFF_HI_LSB]; // RQ10
        end
    end

    // ------------------------------------------------------------------
    // Phase bias outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            phaseBiasCh0High <= 16'h0000;
            phaseBiasCh1Low <= 16'h0000;
            phaseBiasCh1High <= 16'h0000;
        end else begin
            phaseBiasCh0High <= wordCh0High[PCC_BIAS_MSB:0]; // RQ8
            phaseBiasCh1Low <= wordCh1Low[PCC_BIAS_MSB:0]; // RQ9
            phaseBiasCh1High <= wordCh1High[PCC_BIAS_MSB:0]; // RQ10
        end
    end
endmodule

// >>> pcc_chk.sv
// Checker for the phase correction configuration register slice.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module pcc_chk (
    input wire logic clk,
    input wire logic rst,
    input pcc_pkg::pcc_write_type hostWrite,
    input wire logic [7:0] hostReadAddr,
    input wire logic [23:0] hostReadData,
    input wire logic hostReadHit,
    input wire logic autoFrequencySelect,
    input wire logic autoUnwrapEnable,
    input wire logic manualFrequencySelect,
    input wire logic manualUnwrapEnable,
    input pcc_pkg::pcc_unwrap_type unwrapControl,
    input pcc_pkg::pcc_clip_type clipControl,
    input wire logic [1:0] stageSelect,
    input wire logic signed [16:0] stageRawSum,
    input wire logic signed [15:0] stageResult,
    input wire logic [11:0] emitterThermalCoeffCh0High,
    input wire logic [7:0] emitterThermalCoeffCh1LowUpper,
    input wire logic [15:0] phaseBiasCh0High,
    input wire logic [15:0] phaseBiasCh1Low,
    input wire logic [15:0] phaseBiasCh1High
);
    import pcc_pkg::*;
    wire [3:0] clipVec = clipControl;
    wire inMap = hostWrite.wr && hostWrite.addr[7:2] == 6'h14;
    wire [3:0] wrAt = {4{inMap}} & (4'h1 << hostWrite.addr[1:0]);
    // Stage mode is only trusted once the mode word has settled
    wire sat = clipVec[3 - stageSelect] && stageRawSum[16] != stageRawSum[15];
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_unwrap_mux: assert property (!$past(rst) |->
        unwrapControl[1:0] == (unwrapControl.manualOverride ?
        $past({manualFrequencySelect, manualUnwrapEnable}) :
        $past({autoFrequencySelect, autoUnwrapEnable})))
        else $error("unwrap controls do not follow the selected source");
    chk_override_bit: assert property (wrAt[0] |-> ##2
        unwrapControl.manualOverride == $past(hostWrite.data[22], 2))
        else $error("override flag does not follow its write");
    chk_clip_bits: assert property (wrAt[0] |-> ##2
        clipVec == $past(hostWrite.data[3:0], 2))
        else $error("stage modes do not follow their write");
    chk_bias_ch0: assert property (wrAt[1] |-> ##2
        phaseBiasCh0High == $past(hostWrite.data[15:0], 2))
        else $error("channel zero bias wrong");
    chk_coeff_upper: assert property (wrAt[1] |-> ##2
        emitterThermalCoeffCh0High[11:4] == $past(hostWrite.data[23:16], 2))
        else $error("coefficient upper bits wrong");
    chk_coeff_lower: assert property (wrAt[2] |-> ##2
        emitterThermalCoeffCh0High[3:0] == $past(hostWrite.data[23:20], 2))
        else $error("coefficient lower bits wrong");
    chk_bias_ch1lo: assert property (wrAt[2] |-> ##2
        phaseBiasCh1Low == $past(hostWrite.data[15:0], 2))
        else $error("channel one low bias wrong");
    chk_reg_top: assert property (wrAt[3] |-> ##2
        {emitterThermalCoeffCh1LowUpper, phaseBiasCh1High} ==
        $past(hostWrite.data, 2)) else $error("top register fields wrong");
    chk_stage_clip: assert property (!$past(wrAt[0]) && sat |=>
        stageResult == ($past(stageRawSum[16]) ? 16'sh8000 : 16'sh7FFF))
        else $error("saturated stage result wrong");
    chk_stage_wrap: assert property (!$past(wrAt[0]) && !sat |=>
        stageResult == $past(stageRawSum[15:0]))
        else $error("wrapped stage result wrong");
endmodule
bind pcc_phase_correction_config pcc_chk i_chk (.clk, .rst, .hostWrite,
    .hostReadAddr, .hostReadData, .hostReadHit, .autoFrequencySelect,
    .autoUnwrapEnable, .manualFrequencySelect, .manualUnwrapEnable,
    .unwrapControl, .clipControl, .stageSelect, .stageRawSum, .stageResult,
    .emitterThermalCoeffCh0High, .emitterThermalCoeffCh1LowUpper,
    .phaseBiasCh0High, .phaseBiasCh1Low, .phaseBiasCh1High);

// >>> tb_top.sv
// Testbench for the phase correction configuration register slice.
// Assumes the checker is attached by its own bind.
`timescale 1ns/1ps
module tb_top;
    import pcc_pkg::*;
    logic clk = 0, rst = 1, autoFrequencySelect = 0, autoUnwrapEnable = 0;
    logic manualFrequencySelect = 0, manualUnwrapEnable = 0, hostReadHit;
    pcc_write_type hostWrite = '0;
    logic [7:0] hostReadAddr = 8'h00;
    logic [1:0] stageSelect = 2'h0;
    logic signed [16:0] stageRawSum = 17'h00000;
    logic signed [15:0] stageResult;
    logic [23:0] hostReadData;
    pcc_unwrap_type unwrapControl;
    pcc_clip_type clipControl;
    logic [11:0] emitterThermalCoeffCh0High;
    logic [7:0] emitterThermalCoeffCh1LowUpper;
    logic [15:0] phaseBiasCh0High, phaseBiasCh1Low, phaseBiasCh1High;
    logic [3:0] nib;
    int errorCnt = 0, checks = 0;
    // Overflow both ways, then an in-range value that must pass untouched
    logic [16:0] sums [3] = '{17'h08000, 17'h17FFF, 17'h1FFFE};
    logic [15:0] clipExp [3] = '{16'h7FFF, 16'h8000, 16'hFFFE};
    logic [15:0] wrapExp [3] = '{16'h8000, 16'h7FFF, 16'hFFFE};
    pcc_phase_correction_config i_dut (.clk, .rst, .hostWrite,
        .hostReadAddr, .hostReadData, .hostReadHit, .autoFrequencySelect,
        .autoUnwrapEnable, .manualFrequencySelect, .manualUnwrapEnable,
        .unwrapControl, .clipControl, .stageSelect, .stageRawSum,
        .stageResult, .emitterThermalCoeffCh0High,
        .emitterThermalCoeffCh1LowUpper, .phaseBiasCh0High,
        .phaseBiasCh1Low, .phaseBiasCh1High);
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            errorCnt++;
            $display("[FAIL] %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    // Strobe drops for one idle cycle so writes never touch it twice
    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        hostWrite = '{1'b1, a, d};
        @(negedge clk);
        hostWrite.wr = 1'b0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [23:0] e, input h);
        hostReadAddr = a;
        @(negedge clk);
        chk(hostReadData, e);
        chk({23'h0, hostReadHit}, {23'h0, h});
    endtask
    task automatic ovr(input logic [23:0] d, input logic [3:0] v,
            input logic [2:0] e);
        wr(PCC_ADDR_CLIP_MODE, d);
        {autoFrequencySelect, autoUnwrapEnable} = v[3:2];
        {manualFrequencySelect, manualUnwrapEnable} = v[1:0];
        @(negedge clk);
        chk({21'h0, unwrapControl}, {21'h0, e});
    endtask
    task automatic testDone;
        $display("Comparisons %0d, mismatches %0d", checks, errorCnt);
        if (errorCnt == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #20000;
        errorCnt++;
        testDone;
    end
    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(negedge clk);
        rst = 1'b0;
        rd(PCC_ADDR_CLIP_MODE, PCC_RESET_CLIP_MODE, 1'b1);
        rd(PCC_ADDR_CH1_HIGH, PCC_RESET_OTHER, 1'b1);
        $display("Reset values done");
        wr(8'h51, 24'hA51234);
        wr(8'h52, 24'h308765);
        wr(8'h53, 24'h5AF00F);
        wr(8'h54, 24'hFFFFFF);
        wr(8'h4F, 24'hFFFFFF);
        rd(8'h50, PCC_RESET_CLIP_MODE, 1'b1);
        rd(8'h51, 24'hA51234, 1'b1);
        rd(8'h52, 24'h308765, 1'b1);
        rd(8'h53, 24'h5AF00F, 1'b1);
        rd(8'h54, 24'h0, 1'b0);
        chk({12'h0, emitterThermalCoeffCh0High}, 24'hA53);
        chk({8'h0, phaseBiasCh0High}, 24'h1234);
        chk({8'h0, phaseBiasCh1Low}, 24'h8765);
        chk({emitterThermalCoeffCh1LowUpper, phaseBiasCh1High},
            24'h5AF00F);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        rd(8'h51, PCC_RESET_OTHER, 1'b1);
        $display("Register access done");
        for (int s = 0; s < 4; s++) begin
            for (int m = 0; m < 2; m++) begin
                nib = m ? 4'h8 >> s : ~(4'h8 >> s);
                wr(PCC_ADDR_CLIP_MODE, {20'h20010, nib});
                chk({20'h0, clipControl}, {20'h0, nib});
                for (int k = 0; k < 3; k++) begin
                    stageSelect = s[1:0];
                    stageRawSum = sums[k];
                    @(negedge clk);
                    chk({8'h0, stageResult},
                        m ? clipExp[k] : wrapExp[k]);
                end
            end
        end
        $display("Stage modes done");
        ovr(24'h600100, 4'b0010, 3'b110);
        ovr(24'h600100, 4'b1001, 3'b101);
        ovr(24'h200100, 4'b1001, 3'b010);
        $display("Override done");
        testDone;
    end
endmodule
